// file: inc/pnd_pkg.sv
// ****************************************************************
// Shared constants and types
// ****************************************************************
package pnd_pkg;
   localparam int ADDR_W    = 18;    // Full DMA address width
   localparam int DATA_W    = 16;    // Multiplexed bus width
   localparam int WAIT_W    = 3;     // Wait field width
   localparam int INFO_W    = 4;     // Address-information outputs
   localparam int INFO_ALE  = 0;     // Latch strobe position
   localparam int INFO_RDN  = 1;     // Inverted read position
   localparam int INFO_CS_L = 2;     // Low chip-select address bit
   localparam int INFO_CS_H = 3;     // High chip-select address bit
   localparam int BUF_DEPTH = 2;     // Read data buffer entries
   localparam logic [DATA_W-1:0] BUS_PULL = 16'hFFFF; // Floating bus level

   // Bus-master sequence states
   typedef enum logic [2:0] {
      ST_IDLE, ST_TRI, ST_AD1, ST_AD2, ST_ADH, ST_DWAIT, ST_LTX, ST_CU
   } pnd_state_e;

   // Controller sequence states
   typedef enum logic [1:0] {
      CT_REL, CT_START, CT_RUN
   } pnd_ctl_e;
endpackage : pnd_pkg

// file: inc/pnd_if.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Port link between the bus master and its controller
// ****************************************************************
interface pnd_if;
   import pnd_pkg::*;
   logic                address_select_n;       // From controller
   logic                target_ready_n;         // From controller
   logic                initiator_ready_n;      // From master
   logic                end_n;                  // From master, last data cycle
   logic                dma_request_n;          // From master, request pending
   logic                queued_request_n;       // From master, request not started
   logic [INFO_W-1:0]   port_addr_info_outputs; // From master
   logic [DATA_W-1:0]   ad_dev_o;               // Master drive value
   logic                ad_dev_oe_n;            // Master drive enable, low drives
   logic [DATA_W-1:0]   ad_ctl_o;               // Controller drive value
   logic                ad_ctl_oe_n;            // Controller drive enable, low drives
   logic [DATA_W-1:0]   port_addr_data_bus;     // Resolved wire level

   // Resolve the shared lines, pulled high when nobody drives
   assign port_addr_data_bus = !ad_dev_oe_n ? ad_dev_o :
                               (!ad_ctl_oe_n ? ad_ctl_o : BUS_PULL);

   modport dev (
      input  address_select_n, target_ready_n, port_addr_data_bus,
      output initiator_ready_n, end_n, dma_request_n, queued_request_n,
      output port_addr_info_outputs, ad_dev_o, ad_dev_oe_n
   );
   modport ctl (
      output address_select_n, target_ready_n, ad_ctl_o, ad_ctl_oe_n,
      input  initiator_ready_n, end_n, dma_request_n, queued_request_n,
      input  port_addr_info_outputs, port_addr_data_bus
   );
endinterface : pnd_if
`default_nettype wire

// file: rtl/pnd_dev.sv
// Contract
// - Select low, ready high: float, remember state
// - Both low: go to Address1, drive address
// - Address1, Address2, Address Hold keep address
// - Latch strobe falls at Address Hold, stays low
// - Low sixteen address bits on shared lines
// - Address bits 17:16 on info outputs
// - Info pin shows inverted read indication
// - Data Wait until wait timer expires
// - Read wait field delays data sampling
// - Write data held two plus waits (Data Wait and Last Transfer)
// - Timer expiry: Last Transfer, end low, sample
// - Last Transfer then Clean Up, bus floats
// - After Clean Up idle, controls kept
// - Idle held while no request
// - Controller steers follow-on during Last Transfer
// - Controller restarts, releases, or does other
// - Slave drives read data before sampling
// - Address mode on edge, both low
// - Slave latches address on strobe fall
`timescale 1ns/10ps
`default_nettype none
module pnd_dev
   import pnd_pkg::*;
(
   input  wire logic                   CLK,         // System clock
   input  wire logic                   RESET,       // Async reset, high
   pnd_if.dev                          BUS,         // Port link
   input  wire logic                   CMD_VALID,   // New DMA command offered
   output logic                        CMD_READY,   // Command taken when both high
   input  wire logic [pnd_pkg::ADDR_W-1:0] CMD_ADDR, // DMA address
   input  wire logic                   CMD_READ,    // High reads, low writes
   input  wire logic [pnd_pkg::WAIT_W-1:0] CMD_WAITS, // Wait field
   input  wire logic [pnd_pkg::DATA_W-1:0] CMD_WDATA, // Write data
   output logic                        RDATA_VALID, // Read word available
   input  wire logic                   RDATA_READY, // Read word consumed
   output logic [pnd_pkg::DATA_W-1:0]  RDATA,       // Read word
   output logic                        BUSY         // Command in progress
);
   import pnd_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   pnd_state_e             state_q;      // Current bus state
   pnd_state_e             state_d;      // Next bus state
   pnd_state_e             saved_q;      // State left for tri-state
   logic                   pending_q;    // Command accepted, not done
   logic [ADDR_W-1:0]      addr_q;       // Latched address
   logic                   read_q;       // Latched direction
   logic [WAIT_W-1:0]      waits_q;      // Latched wait field
   logic [DATA_W-1:0]      wdata_q;      // Latched write data
   logic [WAIT_W-1:0]      timer_q;      // Data wait timer
   logic                   initiator_ready_n_n_q;     // Initiator ready pin
   logic                   end_n_q;      // End pin
   logic                   ale_n_q;      // Latch strobe pin
   logic                   rdn_q;        // Inverted read pin
   logic [1:0]             cs_q;         // Chip-select address bits
   logic                   oe_n_q;       // Bus drive enable, low drives
   logic [DATA_W-1:0]      ad_q;         // Bus drive value
   logic [DATA_W-1:0]      buf_q [BUF_DEPTH]; // Read data buffer
   logic                   wr_ptr_q;     // Buffer write slot
   logic                   rd_ptr_q;     // Buffer read slot
   logic [1:0]             cnt_q;        // Buffer fill level
   logic                   address_select_n_n;       // Sampled select
   logic                   target_ready_n_n;       // Sampled ready
   logic                   step;         // Select high, ready low
   logic                   last_transfer_next; // Wait timer expired
   logic                   push;         // Read word captured
   logic                   pop;          // Read word consumed
   logic                   accept;       // Command taken

   // Drive enable wanted in a state
   function automatic logic drives(input pnd_state_e s, input logic rd);
      logic d;
      d = 1'b0;
      unique case (s)
         ST_AD1, ST_AD2, ST_ADH: d = 1'b1;  // Address phase
         ST_DWAIT, ST_LTX:       d = !rd;   // Write data only
         ST_IDLE, ST_TRI, ST_CU: d = 1'b0;  // Floating
      endcase
      return d;
   endfunction : drives

   // True for states that keep control pins as they are
   function automatic logic keeps(input pnd_state_e s);
      return (s == ST_IDLE) || (s == ST_TRI);
   endfunction : keeps

   assign address_select_n_n = BUS.address_select_n;
   assign target_ready_n_n = BUS.target_ready_n;
   assign step   = address_select_n_n && !target_ready_n_n;
   assign last_transfer_next = (state_q == ST_DWAIT) && (timer_q == 3'h0);

   // ****************************************************************
   // Next-state decode
   // ****************************************************************
   // Inputs are sampled on the rising edge, as on the pins
   always_comb begin
      state_d = state_q;
      if (!address_select_n_n && target_ready_n_n) begin
         state_d = ST_TRI;
      end else if (!address_select_n_n && !target_ready_n_n) begin
         state_d = ST_AD1;
      end else if (step) begin
         unique case (state_q)
            ST_AD1:   state_d = pending_q ? ST_AD2 : ST_AD1;
            ST_AD2:   state_d = ST_ADH;
            ST_ADH:   state_d = ST_DWAIT;
            ST_DWAIT: state_d = last_transfer_next ? ST_LTX : ST_DWAIT;
            ST_LTX:   state_d = ST_CU;
            ST_CU:    state_d = ST_IDLE;
            ST_IDLE:  state_d = ST_IDLE;
            ST_TRI:   state_d = saved_q;                    // Resume left state
         endcase
      end
      // Select and ready both high hold every state
   end

   // ****************************************************************
   // State registers
   // ****************************************************************
   // Bus state, reset waits floating for the controller
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Remember the state left when the bus is released
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         saved_q <= ST_IDLE;
      end else if (state_d == ST_TRI && state_q != ST_TRI) begin
         saved_q <= state_q;
      end
   end

   // Wait timer, loaded on entry to Data Wait
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         timer_q <= 3'h0;
      end else if (state_q == ST_ADH && state_d == ST_DWAIT) begin
         timer_q <= waits_q;
      end else if (state_q == ST_DWAIT && step && !last_transfer_next) begin
         timer_q <= timer_q - 3'h1;                         // Count down one wait
      end
   end

   // ****************************************************************
   // Command intake
   // ****************************************************************
   assign CMD_READY = !pending_q && (cnt_q != 2'h2);
   assign accept    = CMD_VALID && CMD_READY;
   assign BUSY      = pending_q;

   // Latch a command, done when Last Transfer ends
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         pending_q <= 1'b0;
      end else if (accept) begin
         pending_q <= 1'b1;
      end else if (state_q == ST_LTX && state_d == ST_CU) begin
         pending_q <= 1'b0;
      end
   end

   // Command fields
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         addr_q  <= '0;
         read_q  <= 1'b0;
         waits_q <= 3'h0;
         wdata_q <= 16'h0000;
      end else if (accept) begin
         addr_q  <= CMD_ADDR;
         read_q  <= CMD_READ;
         waits_q <= CMD_WAITS;
         wdata_q <= CMD_WDATA;
      end
   end

   // Request pins: queued holds in Idle, Tri-state and Clean Up while a command is pending
   assign BUS.dma_request_n    = !pending_q;
   assign BUS.queued_request_n = !(pending_q &&
      (state_q == ST_IDLE || state_q == ST_TRI || state_q == ST_CU));

   // ****************************************************************
   // Control pins
   // ****************************************************************
   // Ready and end follow the next state, kept in Idle and Tri-state
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         initiator_ready_n_n_q <= 1'b1;
         end_n_q  <= 1'b1;
      end else if (!keeps(state_d)) begin
         end_n_q <= (state_d != ST_LTX);
         if (state_d == ST_AD1 || state_d == ST_CU) begin
            initiator_ready_n_n_q <= 1'b1;
         end else if (state_d == ST_DWAIT && target_ready_n_n) begin
            initiator_ready_n_n_q <= 1'b1;
         end else begin
            initiator_ready_n_n_q <= 1'b0;                               // Transfer running
         end
      end
   end

   // Strobe, direction and chip selects, kept in Idle and Tri-state
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ale_n_q <= 1'b1;
         rdn_q   <= 1'b1;
         cs_q    <= 2'h0;
      end else if (!keeps(state_d)) begin
         ale_n_q <= (state_d == ST_AD1) || (state_d == ST_AD2);
         if (state_d == ST_AD1) begin
            rdn_q <= !read_q;
            cs_q  <= addr_q[ADDR_W-1:DATA_W];
         end
      end
   end

   assign BUS.initiator_ready_n = initiator_ready_n_n_q;
   assign BUS.end_n             = end_n_q;
   assign BUS.port_addr_info_outputs = {cs_q, rdn_q, ale_n_q};

   // ****************************************************************
   // Multiplexed bus drive
   // ****************************************************************
   // Address in the three address states, write data after
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         oe_n_q <= 1'b1;
         ad_q   <= 16'h0000;
      end else begin
         oe_n_q <= !drives(state_d, read_q);
         if (state_d == ST_AD1 || state_d == ST_AD2 || state_d == ST_ADH) begin
            ad_q <= addr_q[DATA_W-1:0];
         end else begin
            ad_q <= wdata_q;
         end
      end
   end

   assign BUS.ad_dev_o    = ad_q;
   assign BUS.ad_dev_oe_n = oe_n_q;

   // ****************************************************************
   // Read data buffer
   // ****************************************************************
   // Sample the bus when the wait timer runs out
   assign push = read_q && state_q == ST_DWAIT && state_d == ST_LTX;
   assign pop  = RDATA_VALID && RDATA_READY;

   // Buffer storage, the intake stall keeps a slot free
   always_ff @(posedge CLK) begin
      if (push) begin
         buf_q[wr_ptr_q] <= BUS.port_addr_data_bus;
      end
   end

   // Buffer pointers and fill level
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q    <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= !wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= !rd_ptr_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end

   assign RDATA_VALID = (cnt_q != 2'h0);
   assign RDATA       = buf_q[rd_ptr_q];
endmodule : pnd_dev
`default_nettype wire

// file: rtl/pnd_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module pnd_ctl
   import pnd_pkg::*;
(
   input  wire logic                       CLK,        // System clock
   input  wire logic                       RESET,      // Async reset, high
   pnd_if.ctl                              BUS,        // Port link
   input  wire logic                       STALL,      // Holds ready high
   input  wire logic                       PARK,       // Idle instead of release
   input  wire logic [pnd_pkg::DATA_W-1:0] RD_DATA,    // Data returned on reads
   output logic                            ADDR_VALID, // Address latched pulse
   output logic [pnd_pkg::ADDR_W-1:0]      ADDR,       // Latched address
   output logic                            WR_VALID,   // Write word pulse
   output logic [pnd_pkg::DATA_W-1:0]      WR_DATA     // Written word
);
   import pnd_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   pnd_ctl_e           st_q;       // Controller state
   logic               address_select_n_n_q;   // Select pin
   logic               target_ready_n_n_q;   // Ready pin
   logic               ale_prev_q; // Strobe one cycle ago
   logic               end_prev_q; // End one cycle ago
   logic [DATA_W-1:0]  rd_q;       // Registered read data
   logic               ale_n;      // Strobe from info pins
   logic               rdn;        // Inverted read from info pins
   logic               end_seen;   // Last Transfer detected once

   assign ale_n    = BUS.port_addr_info_outputs[INFO_ALE];
   assign rdn      = BUS.port_addr_info_outputs[INFO_RDN];
   assign end_seen = !BUS.end_n && end_prev_q;

   // ****************************************************************
   // Steering of select and ready
   // ****************************************************************
   // Choose the follow-on while Last Transfer is seen
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_q     <= CT_REL;
         address_select_n_n_q <= 1'b0;
         target_ready_n_n_q <= 1'b1;
      end else begin
         unique case (st_q)
            CT_REL: begin
               if (!BUS.queued_request_n) begin
                  st_q     <= CT_START;
                  target_ready_n_n_q <= 1'b0;
               end
            end
            CT_START: begin
               st_q     <= CT_RUN;
               address_select_n_n_q <= 1'b1;
               target_ready_n_n_q <= STALL;
            end
            CT_RUN: begin
               target_ready_n_n_q <= STALL;
               if (end_seen && !PARK) begin
                  st_q     <= CT_REL;
                  address_select_n_n_q <= 1'b0;
                  target_ready_n_n_q <= 1'b1;
               end else if (!BUS.queued_request_n) begin
                  st_q     <= CT_START;
                  address_select_n_n_q <= 1'b0;
                  target_ready_n_n_q <= 1'b0;
               end
            end
            default: begin
               st_q <= CT_REL;                              // Unused code, back to CT_REL, select and ready kept
            end
         endcase
      end
   end

   assign BUS.address_select_n = address_select_n_n_q;
   assign BUS.target_ready_n   = target_ready_n_n_q;

   // ****************************************************************
   // Slave side
   // ****************************************************************
   // Edge history for strobe and end
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ale_prev_q <= 1'b1;
         end_prev_q <= 1'b1;
         rd_q       <= 16'h0000;
      end else begin
         ale_prev_q <= ale_n;
         end_prev_q <= BUS.end_n;
         rd_q       <= RD_DATA;
      end
   end

   // Address latched on the strobe's falling edge
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ADDR_VALID <= 1'b0;
         ADDR       <= '0;
      end else begin
         ADDR_VALID <= ale_prev_q && !ale_n;
         if (ale_prev_q && !ale_n) begin
            ADDR <= {BUS.port_addr_info_outputs[INFO_CS_H:INFO_CS_L],
                     BUS.port_addr_data_bus};
         end
      end
   end

   // Write word taken while end is low
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         WR_VALID <= 1'b0;
         WR_DATA  <= 16'h0000;
      end else begin
         WR_VALID <= end_seen && rdn;
         if (end_seen && rdn) begin
            WR_DATA <= BUS.port_addr_data_bus;
         end
      end
   end

   // Read data driven through Data Wait, after Address Hold
   assign BUS.ad_ctl_oe_n = !(!ale_n && !ale_prev_q && !BUS.initiator_ready_n &&
                              BUS.end_n && !rdn);
   assign BUS.ad_ctl_o    = rd_q;
endmodule : pnd_ctl
`default_nettype wire

// file: test/pnd_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// Link checks
// ****************
module pnd_assertions (
   input wire logic       CLK,
   input wire logic       RESET,
   input wire logic       address_select_n,
   input wire logic       target_ready_n,
   input wire logic       initiator_ready_n,
   input wire logic       end_n,
   input wire logic [3:0] port_addr_info_outputs,
   input wire logic       ad_dev_oe_n
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   wire ale_n = port_addr_info_outputs[0]; // Latch strobe, low active

   a_release_float: assert property (!address_select_n && target_ready_n |=> ad_dev_oe_n)
      else $error("bus not released");
   a_address_entry: assert property (!address_select_n && !target_ready_n
      |=> !ad_dev_oe_n && initiator_ready_n && end_n && ale_n) else $error("no address entry");
   a_strobe_address: assert property ($fell(ale_n) |-> !ad_dev_oe_n && !$past(ad_dev_oe_n, 2))
      else $error("strobe without address");
   a_end_cleanup: assert property (!end_n && address_select_n && !target_ready_n
      |=> end_n && initiator_ready_n && ad_dev_oe_n && !ale_n) else $error("bad clean up");
   a_info_stable: assert property (!initiator_ready_n ##1 !initiator_ready_n
      |-> $stable(port_addr_info_outputs[3:1])) else $error("info moved in transfer");
   a_write_drive: assert property (!end_n && port_addr_info_outputs[1] |-> !ad_dev_oe_n)
      else $error("write data not driven");
   a_read_float: assert property (!end_n && !port_addr_info_outputs[1] |-> ad_dev_oe_n)
      else $error("read lines driven");
   a_stall_hold: assert property (address_select_n && target_ready_n && end_n && !ale_n
      |=> end_n) else $error("advanced while stalled");
endmodule : pnd_assertions
`default_nettype wire

// file: test/port2_nonburst_dma_bus_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// Bench for both link ends
// ****************
module port2_nonburst_dma_bus_bench;
   import pnd_pkg::*;
   logic              clk, reset, cmd_valid, cmd_ready, cmd_read, rdata_valid, rdata_ready;
   logic              busy, stall, park, addr_valid, wr_valid;
   logic [ADDR_W-1:0] cmd_addr, addr;
   logic [WAIT_W-1:0] cmd_waits;
   logic [DATA_W-1:0] cmd_wdata, rdata, rd_data, wr_data;
   logic [DATA_W-1:0] q[$];        // Expected read words
   int                n_fail, num_checks;
   pnd_if bus ();
   pnd_dev i_pnd_dev (.CLK(clk), .RESET(reset), .BUS(bus), .CMD_VALID(cmd_valid),
      .CMD_READY(cmd_ready), .CMD_ADDR(cmd_addr), .CMD_READ(cmd_read), .CMD_WAITS(cmd_waits),
      .CMD_WDATA(cmd_wdata), .RDATA_VALID(rdata_valid), .RDATA_READY(rdata_ready),
      .RDATA(rdata), .BUSY(busy));
   pnd_ctl i_pnd_ctl (.CLK(clk), .RESET(reset), .BUS(bus), .STALL(stall), .PARK(park),
      .RD_DATA(rd_data), .ADDR_VALID(addr_valid), .ADDR(addr), .WR_VALID(wr_valid),
      .WR_DATA(wr_data));
   pnd_assertions i_pnd_assertions (.CLK(clk), .RESET(reset),
      .address_select_n(bus.address_select_n), .target_ready_n(bus.target_ready_n),
      .initiator_ready_n(bus.initiator_ready_n), .end_n(bus.end_n),
      .port_addr_info_outputs(bus.port_addr_info_outputs), .ad_dev_oe_n(bus.ad_dev_oe_n));

   // Free-running clock
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   // Counts, verdict and end of run
   task complete_run;
      $display("Checks %0d, failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run

   // Compares a value seen against its expectation
   task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // A wait ran out of bound
   task wait_expired;
      n_fail++;
      $display("[FAIL] wait bound expected done seen expired");
      complete_run();
   endtask : wait_expired

   // One cycle, inputs move just after the edge
   task step;
      @(posedge clk);
      #1;
   endtask : step

   // Offers one command and watches the link until it ends
   task xfer(input logic rd, input logic [17:0] a, input logic [2:0] w, input logic [15:0] d,
             input int s);
      int   i, cnt;
      logic sa, se, sw, prev;
      cmd_read = rd;
      cmd_addr = a;
      cmd_waits = w;
      cmd_wdata = d;
      rd_data = d;
      cmd_valid = 1;
      for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) step();
      if (i == 50) wait_expired();
      step();
      cmd_valid = 0;
      chk("busy flag", 1, busy); // Command held until Last Transfer ends
      chk("request pin", 0, bus.dma_request_n);
      chk("queued request", 0, bus.queued_request_n);
      if (rd) q.push_back(d);
      sa = 0;
      se = 0;
      sw = rd;
      prev = bus.port_addr_info_outputs[0]; // Strobe may idle low, no false fall
      cnt = -1;
      for (i = 0; i < 60 && !(sa && se && sw); i++) begin
         step();
         if (cnt >= 0) cnt++;
         if (cnt == s) stall = 0;
         if (prev && !bus.port_addr_info_outputs[0] && cnt < 0) begin
            cnt = 0;
            stall = (s != 0);
            chk("address lines", a[15:0], bus.port_addr_data_bus);
            chk("chip select bits", a[17:16], bus.port_addr_info_outputs[3:2]);
            chk("read indication", !rd, bus.port_addr_info_outputs[1]);
         end
         prev = bus.port_addr_info_outputs[0];
         if (!bus.end_n && !se) begin
            se = 1;
            chk("wait count", 18'(w + 2 + s), 18'(cnt));
         end
         if (addr_valid) begin
            sa = 1;
            chk("latched address", a, addr);
         end
         if (wr_valid) begin
            sw = 1;
            chk("write word", d, wr_data);
         end
      end
      if (i == 60) wait_expired();
   endtask : xfer

   // Takes every buffered read word in order
   task drain;
      int i;
      while (q.size() > 0) begin
         for (i = 0; i < 50 && rdata_valid !== 1'b1; i++) step();
         if (i == 50) wait_expired();
         chk("read word", q.pop_front(), rdata);
         rdata_ready = 1;                         // Held up between words
         step();
      end
      rdata_ready = 0;
      chk("buffer empty", 0, rdata_valid);
   endtask : drain

   // Main sequence
   initial begin
      {reset, cmd_valid, cmd_read, rdata_ready, stall, park} = 6'h20;
      {cmd_addr, cmd_waits, cmd_wdata, rd_data} = '0;
      n_fail = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      #1 reset = 0;
      chk("device drive enable", 1, bus.ad_dev_oe_n);
      chk("initiator ready", 1, bus.initiator_ready_n);
      chk("end strobe", 1, bus.end_n);
      for (int k = 0; k < 8; k++) xfer(0, {k[1:0], 16'h5A00 + 16'(k)}, k[2:0], 16'hC3C0 ^ 16'(k), 0);
      xfer(1, 18'h3FFFF, 3'h0, 16'h1234, 0);
      xfer(1, 18'h10001, 3'h7, 16'hEDCB, 0);
      repeat (4) step();
      chk("command refused", 0, cmd_ready); // Buffer holds two words
      drain();
      xfer(1, 18'h2ABCD, 3'h4, 16'h0F0F, 3);
      drain();
      park = 1;
      xfer(0, 18'h0C0DE, 3'h2, 16'hBEEF, 0);
      repeat (4) step();
      chk("idle bus float", BUS_PULL, bus.port_addr_data_bus);
      chk("idle strobe kept", 0, bus.port_addr_info_outputs[0]);
      chk("idle request", 1, bus.dma_request_n);
      xfer(1, 18'h3F00F, 3'h1, 16'hA55A, 0);
      drain();
      complete_run();
   end
endmodule : port2_nonburst_dma_bus_bench
`default_nettype wire
